// >>> hw/pdtc_counter.sv
// Preset down-counter relay unit
`timescale 1ns/1ps
`default_nettype none
module pdtc_counter import pdtc_pkg::*; (
	input wire logic clk,
	input wire logic reset,
	input wire logic clkEn,
	pdtc_unit_if.unit u
);
	pdtc_val_t pv_q, pv_d;
	logic contact_q, contact_d;
	logic loaded_q, loaded_d;
	logic coilPrev_q, coilPrev_d;

	always_comb begin
		pv_d = pv_q;
		contact_d = contact_q;
		loaded_d = loaded_q;
		coilPrev_d = u.coil;
		if (u.clear) begin
			pv_d = u.setValue;
			contact_d = 1'b0;
			loaded_d = 1'b0;
		end else if (!contact_q) begin
			if (u.coil && !loaded_q) begin
				// A zero preset would wrap; treat it as already done
				pv_d = (u.setValue == VAL_ZERO) ? VAL_ZERO : u.setValue - VAL_ONE;
				loaded_d = 1'b1;
				contact_d = (pv_d == VAL_ZERO);
			end else if (u.coil && !coilPrev_q && loaded_q) begin
				pv_d = pv_q - VAL_ONE;
				contact_d = (pv_d == VAL_ZERO);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			pv_q <= VAL_ZERO;
			contact_q <= 1'b0;
			loaded_q <= 1'b0;
			coilPrev_q <= 1'b0;
		end else if (clkEn) begin
			pv_q <= pv_d;
			contact_q <= contact_d;
			loaded_q <= loaded_d;
			coilPrev_q <= coilPrev_d;
		end
	end

	assign u.presentValue = pv_q;
	assign u.contact = contact_q;
	assign u.armed = loaded_q;
endmodule
`default_nettype wire

// >>> hw/pdtc_pkg.sv
// Shared widths, reset values and types for the timer, counter and sequencer block
// Contract
// - An energized timer coil keeps its contacts open during the delay.
// - The set value sets the timer delay length.
// - After the delay, contacts stay closed while the coil stays energized.
// - Coil drop opens an elapsed timer's contacts at once.
// - Coil drop before the delay ends resets timing; contacts never close.
// - Re-energizing restarts a full delay from the set value.
// - First counter energization after a clear loads set value minus one, or zero for a zero preset.
// - Each later coil off-to-on transition before the count reaches zero decrements the count by one.
// - A coil that stays energized causes no further decrement.
// - Count reaching zero turns the counter contacts on.
// - Counter contacts stay on regardless of coil until cleared.
// - Program pulses the counter clear; counter drops contacts and re-arms.
// - The sequencer step counter always holds the active step number.
// - Steps advance from initial to final step, then wrap to initial.
// - Every step has its own active indication output.
package pdtc_pkg;
	localparam int VAL_W = 16;
	localparam int STEP_W = 5;
	localparam int STEP_COUNT = 32;
	typedef logic [VAL_W-1:0] pdtc_val_t;
	typedef logic [STEP_W-1:0] pdtc_step_t;
	localparam pdtc_val_t VAL_ZERO = 16'h0000;
	localparam pdtc_val_t VAL_ONE = 16'h0001;
	localparam pdtc_step_t STEP_RESET = 5'h00;
	localparam pdtc_step_t STEP_ONE = 5'h01;
	localparam logic [STEP_COUNT-1:0] STEP_ACTIVE_RESET = 32'h0000_0001;
endpackage

// >>> hw/pdtc_timer.sv
// On-delay timer relay unit
`timescale 1ns/1ps
`default_nettype none
module pdtc_timer import pdtc_pkg::*; (
	input wire logic clk,
	input wire logic reset,
	input wire logic clkEn,
	pdtc_unit_if.unit u
);
	pdtc_val_t pv_q, pv_d;
	logic contact_q, contact_d;

	always_comb begin
		pv_d = pv_q;
		contact_d = contact_q;
		if (!u.coil) begin
			// Reloading while idle makes every energization a fresh full delay
			pv_d = u.setValue;
			contact_d = 1'b0;
		end else begin
			if (u.tick && pv_q != VAL_ZERO) begin
				pv_d = pv_q - VAL_ONE;
			end
			contact_d = (pv_d == VAL_ZERO);
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			pv_q <= VAL_ZERO;
			contact_q <= 1'b0;
		end else if (clkEn) begin
			pv_q <= pv_d;
			contact_q <= contact_d;
		end
	end

	assign u.presentValue = pv_q;
	assign u.contact = contact_q;
	assign u.armed = u.coil & ~contact_q;
endmodule
`default_nettype wire

// >>> hw/pdtc_top.sv
// Top of the delay timer, down counter and step sequencer block
`timescale 1ns/1ps
`default_nettype none
module pdtc_top import pdtc_pkg::*; (
	input wire logic clk,
	input wire logic reset,
	input wire logic clkEn,
	input wire logic tickStrobe,
	input wire logic timerCoil,
	input wire logic [VAL_W-1:0] timerSetValue,
	output logic timerContact,
	output logic [VAL_W-1:0] timerPresentValue,
	input wire logic ctrCoil,
	input wire logic [VAL_W-1:0] ctrSetValue,
	input wire logic counterClearFunction,
	output logic ctrContact,
	output logic [VAL_W-1:0] ctrPresentValue,
	input wire logic seqAdvance,
	input wire logic seqClear,
	input wire logic [STEP_W-1:0] seqLastStep,
	output logic [STEP_W-1:0] seqStep,
	output logic [STEP_COUNT-1:0] seqStepActive
);
	pdtc_unit_if tmrIf();
	pdtc_unit_if ctrIf();

	assign tmrIf.coil = timerCoil;
	assign tmrIf.clear = 1'b0;
	assign tmrIf.tick = tickStrobe;
	assign tmrIf.setValue = timerSetValue;

	// Counting is edge based, so the time base is of no use here
	assign ctrIf.coil = ctrCoil;
	assign ctrIf.clear = counterClearFunction;
	assign ctrIf.tick = 1'b0;
	assign ctrIf.setValue = ctrSetValue;

	pdtc_timer uTimer (
		.clk(clk),
		.reset(reset),
		.clkEn(clkEn),
		.u(tmrIf.unit)
	);

	pdtc_counter uCounter (
		.clk(clk),
		.reset(reset),
		.clkEn(clkEn),
		.u(ctrIf.unit)
	);

	// Unit state is already registered inside each unit
	assign timerContact = tmrIf.contact;
	assign timerPresentValue = tmrIf.presentValue;
	assign ctrContact = ctrIf.contact;
	assign ctrPresentValue = ctrIf.presentValue;

	// Step sequencer
	pdtc_step_t step_q, step_d;
	logic advPrev_q, advPrev_d;
	logic [STEP_COUNT-1:0] active_q, active_d;
	logic advEdge;

	assign advEdge = seqAdvance & ~advPrev_q;

	always_comb begin
		step_d = step_q;
		advPrev_d = seqAdvance;
		if (seqClear) begin
			step_d = STEP_RESET;
		end else if (advEdge) begin
			// Also wraps if the last step was lowered below the current one
			if (step_q >= seqLastStep) begin
				step_d = STEP_RESET;
			end else begin
				step_d = step_q + STEP_ONE;
			end
		end
	end

	for (genvar i = 0; i < STEP_COUNT; i++) begin : gStep
		assign active_d[i] = (step_d == pdtc_step_t'(i));
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			step_q <= STEP_RESET;
			advPrev_q <= 1'b0;
			active_q <= STEP_ACTIVE_RESET;
		end else if (clkEn) begin
			step_q <= step_d;
			advPrev_q <= advPrev_d;
			active_q <= active_d;
		end
	end

	assign seqStep = step_q;
	assign seqStepActive = active_q;

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_timerElapsed;
		clkEn && timerCoil && tmrIf.presentValue == VAL_ZERO;
	endsequence

	sequence s_ctrRise;
		clkEn && ctrCoil && !$past(ctrCoil) && $past(clkEn);
	endsequence

	sequence s_ctrArmed;
		!counterClearFunction && ctrIf.armed && !ctrContact;
	endsequence

	sequence s_seqWrapEdge;
		clkEn && !seqClear && advEdge && seqStep >= seqLastStep;
	endsequence

	a_timer_no_early: assert property (timerContact |-> tmrIf.presentValue == VAL_ZERO)
		else $error("timer contact closed before delay ended");

	a_timer_reload_sv: assert property (clkEn && !timerCoil |=>
		tmrIf.presentValue == $past(timerSetValue))
		else $error("timer not reloaded with set value");

	a_timer_hold_closed: assert property (s_timerElapsed |=> timerContact)
		else $error("elapsed timer contact not closed");

	a_timer_drop_open: assert property (clkEn && !timerCoil |=> !timerContact)
		else $error("timer contact not opened on coil drop");

	a_timer_abort_clean: assert property (clkEn && !timerCoil ##1
		clkEn && timerCoil && tmrIf.presentValue > VAL_ONE |=> !timerContact)
		else $error("aborted timing closed contact early");

	a_timer_fresh_start: assert property (clkEn && !timerCoil ##1
		clkEn && timerCoil && !tickStrobe |=> tmrIf.presentValue == $past(timerSetValue, 2))
		else $error("timer did not start from full set value");

	a_timer_tick_dec: assert property (clkEn && timerCoil && $past(timerCoil)
		&& tickStrobe && tmrIf.presentValue != VAL_ZERO
		|=> tmrIf.presentValue == $past(tmrIf.presentValue) - VAL_ONE)
		else $error("timer did not decrement on tick");

	a_ctr_first_load: assert property (clkEn && ctrCoil && !ctrIf.armed &&
		!counterClearFunction && ctrSetValue != VAL_ZERO
		|=> ctrPresentValue == $past(ctrSetValue) - VAL_ONE && ctrIf.armed)
		else $error("counter first load not set value minus one");

	a_ctr_edge_dec: assert property (s_ctrRise and s_ctrArmed
		|=> ctrPresentValue == $past(ctrPresentValue) - VAL_ONE)
		else $error("counter did not decrement on coil edge");

	a_ctr_level_hold: assert property (clkEn && ctrCoil && $past(ctrCoil) &&
		$past(clkEn) && !counterClearFunction && ctrIf.armed
		|=> ctrPresentValue == $past(ctrPresentValue))
		else $error("counter decremented on steady coil");

	a_ctr_zero_on: assert property (clkEn && !counterClearFunction && ctrIf.armed &&
		ctrPresentValue == VAL_ONE ##0 s_ctrRise |=> ctrContact)
		else $error("counter contact not on at zero");

	a_ctr_latched: assert property (ctrContact && !(clkEn && counterClearFunction)
		|=> ctrContact && ctrPresentValue == VAL_ZERO)
		else $error("counter contact or zero count not held");

	a_ctr_clear: assert property (clkEn && counterClearFunction
		|=> !ctrContact && !ctrIf.armed)
		else $error("counter clear did not drop contact and re-arm");

	a_seq_step_adv: assert property (clkEn && !seqClear && advEdge &&
		seqStep < seqLastStep |=> seqStep == $past(seqStep) + STEP_ONE)
		else $error("sequencer did not advance one step");

	a_seq_wrap: assert property (s_seqWrapEdge |=> seqStep == STEP_RESET)
		else $error("sequencer did not wrap to initial step");

	a_seq_onehot: assert property ($onehot(seqStepActive) &&
		seqStepActive[seqStep])
		else $error("step indication does not match step");

	// Reference delay: ticks seen since energizing, against the set value
	// captured while the coil was low. Kept apart from the unit's own count
	// so that a wrong reload or a skipped tick shows up as a mismatch.
	pdtc_val_t refTicks_q, refTicks_d;
	pdtc_val_t refSv_q, refSv_d;

	always_comb begin
		refTicks_d = refTicks_q;
		refSv_d = refSv_q;
		if (!timerCoil) begin
			refTicks_d = VAL_ZERO;
			refSv_d = timerSetValue;
		end else if (tickStrobe && refTicks_q != refSv_q) begin
			refTicks_d = refTicks_q + VAL_ONE;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			refTicks_q <= VAL_ZERO;
			refSv_q <= VAL_ZERO;
		end else if (clkEn) begin
			refTicks_q <= refTicks_d;
			refSv_q <= refSv_d;
		end
	end

	// A low clock enable must freeze every register, ticks and edges included
	sequence s_frozen;
		!clkEn;
	endsequence

	sequence s_timerWaiting;
		clkEn && timerCoil && !tickStrobe;
	endsequence

	sequence s_timerLastTick;
		clkEn && timerCoil && tickStrobe && tmrIf.presentValue == VAL_ONE;
	endsequence

	sequence s_timerRefDone;
		clkEn && timerCoil && refTicks_q == refSv_q;
	endsequence

	sequence s_ctrIdle;
		clkEn && !counterClearFunction && !ctrCoil;
	endsequence

	sequence s_ctrZeroLoad;
		clkEn && !counterClearFunction && ctrCoil && !ctrIf.armed &&
		ctrSetValue == VAL_ZERO;
	endsequence

	sequence s_seqIdle;
		clkEn && !seqClear && !advEdge;
	endsequence

	a_timer_frozen: assert property (s_frozen |=>
		$stable(timerPresentValue) && $stable(timerContact))
		else $error("timer state moved while clock enable low");

	a_ctr_frozen: assert property (s_frozen |=>
		$stable(ctrPresentValue) && $stable(ctrContact))
		else $error("counter state moved while clock enable low");

	a_seq_frozen: assert property (s_frozen |=>
		$stable(seqStep) && $stable(seqStepActive))
		else $error("sequencer moved while clock enable low");

	a_timer_wait_hold: assert property (s_timerWaiting |=>
		$stable(tmrIf.presentValue))
		else $error("timer counted without a tick");

	a_timer_last_tick: assert property (s_timerLastTick |=>
		timerContact && tmrIf.presentValue == VAL_ZERO)
		else $error("timer contact not closed on last tick");

	a_timer_ref_early: assert property (timerContact |-> refTicks_q == refSv_q)
		else $error("timer contact closed before set value ticks");

	a_timer_ref_late: assert property (s_timerRefDone |=> timerContact)
		else $error("timer contact open after set value ticks");

	a_timer_pv_tracks: assert property (clkEn && timerCoil |=>
		tmrIf.presentValue == refSv_q - refTicks_q)
		else $error("timer present value off the reference count");

	a_ctr_idle_hold: assert property (s_ctrIdle |=>
		$stable(ctrPresentValue) && $stable(ctrContact))
		else $error("counter moved with coil low");

	a_ctr_clear_load: assert property (clkEn && counterClearFunction |=>
		ctrPresentValue == $past(ctrSetValue))
		else $error("counter clear did not load set value");

	a_ctr_zero_load: assert property (s_ctrZeroLoad |=>
		ctrContact && ctrPresentValue == VAL_ZERO)
		else $error("zero preset did not close counter contact");

	a_ctr_contact_zero: assert property (ctrContact |-> ctrPresentValue == VAL_ZERO)
		else $error("counter contact on with nonzero count");

	a_ctr_arm_kept: assert property (ctrIf.armed && !(clkEn && counterClearFunction)
		|=> ctrIf.armed)
		else $error("counter lost its load before a clear");

	a_ctr_rise_ignored: assert property (s_ctrRise ##0 ctrContact &&
		!counterClearFunction |=> ctrContact && $stable(ctrPresentValue))
		else $error("latched counter reacted to a coil edge");

	a_seq_clear_step: assert property (clkEn && seqClear |=> seqStep == STEP_RESET &&
		seqStepActive == STEP_ACTIVE_RESET)
		else $error("sequencer clear did not return to initial step");

	a_seq_idle_hold: assert property (s_seqIdle |=>
		$stable(seqStep) && $stable(seqStepActive))
		else $error("sequencer moved without an advance edge");
endmodule
`default_nettype wire

// >>> hw/pdtc_unit_if.sv
// Signals between the top and one timer or counter unit
`timescale 1ns/1ps
`default_nettype none
interface pdtc_unit_if import pdtc_pkg::*; ();
	logic coil;
	logic clear;
	logic tick;
	pdtc_val_t setValue;
	pdtc_val_t presentValue;
	logic contact;
	logic armed;
	modport unit (input coil, input clear, input tick, input setValue,
		output presentValue, output contact, output armed);
	modport ctrl (output coil, output clear, output tick, output setValue,
		input presentValue, input contact, input armed);
endinterface
`default_nettype wire

// >>> tb/pdtc_ladder.sv
// Ladder program scan model: time-base tick strobe for the timer
`timescale 1ns/1ps
`default_nettype none
module pdtc_ladder (
	input wire logic clk,
	input wire logic reset,
	output logic tickStrobe
);
	logic [1:0] phase;
	// Tick every second cycle so that untimed cycles show no decrement
	// Reset alone sets the phase, so the strobe has a single driver
	always @(negedge clk) begin
		phase <= reset ? 2'h0 : phase + 2'h1;
		tickStrobe <= !reset && phase[0];
	end
endmodule
`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench for the timer, counter and sequencer block
`timescale 1ns/1ps
`default_nettype none
module tb import pdtc_pkg::*; ;
	logic clk = 1'b0;
	logic reset, clkEn, tickStrobe, timerCoil, timerContact, ctrCoil;
	logic counterClearFunction, ctrContact, seqAdvance, seqClear;
	pdtc_val_t timerSetValue, timerPresentValue, ctrSetValue, ctrPresentValue;
	pdtc_step_t seqLastStep, seqStep;
	logic [STEP_COUNT-1:0] seqStepActive;
	int bad_count = 0;
	int compares = 0;
	int cycles = 0;

	always #2.5 clk = !clk;

	pdtc_ladder partner_u (.clk(clk), .reset(reset), .tickStrobe(tickStrobe));

	pdtc_top dut_u (.clk(clk), .reset(reset), .clkEn(clkEn), .tickStrobe(tickStrobe),
		.timerCoil(timerCoil), .timerSetValue(timerSetValue), .timerContact(timerContact),
		.timerPresentValue(timerPresentValue), .ctrCoil(ctrCoil), .ctrSetValue(ctrSetValue),
		.counterClearFunction(counterClearFunction), .ctrContact(ctrContact),
		.ctrPresentValue(ctrPresentValue), .seqAdvance(seqAdvance), .seqClear(seqClear),
		.seqLastStep(seqLastStep), .seqStep(seqStep), .seqStepActive(seqStepActive));

	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Hang guard, far above the few hundred cycles the scenarios need
	always @(posedge clk) begin
		cycles++;
		if (cycles == 1000) begin
			bad_count++;
			final_report();
		end
	end

	task automatic run_timer(input pdtc_val_t sv, input logic [31:0] pat);
		pdtc_val_t pv;
		logic c;
		pv = sv;
		for (int i = 0; i < 32; i++) begin
			@(negedge clk);
			timerSetValue = sv;
			timerCoil = pat[i];
			@(posedge clk);
			if (!timerCoil)
				pv = sv;
			else if (tickStrobe && pv != VAL_ZERO)
				pv = pv - VAL_ONE;
			c = timerCoil && pv == VAL_ZERO;
			#1;
			chk(32'(timerPresentValue), 32'(pv));
			chk(32'(timerContact), 32'(c));
		end
	endtask

	task automatic timer_delay();
		run_timer(16'h0003, 32'h0000_1ffe);
		run_timer(16'h0000, 32'h0000_000c);
	endtask

	// Abort after two ticks, then a full fresh delay
	task automatic timer_abort();
		run_timer(16'h0005, 32'h007f_ff1e);
	endtask

	task automatic run_ctr(input pdtc_val_t sv, input logic [31:0] coilPat,
		input logic [31:0] clrPat);
		pdtc_val_t pv;
		logic c, armed, prev;
		pv = VAL_ZERO;
		{c, armed, prev} = 3'h0;
		for (int i = 0; i < 32; i++) begin
			@(negedge clk);
			ctrSetValue = sv;
			ctrCoil = coilPat[i];
			counterClearFunction = clrPat[i];
			@(posedge clk);
			if (counterClearFunction) begin
				pv = sv;
				c = 1'b0;
				armed = 1'b0;
			end else if (!c && ctrCoil && !armed) begin
				pv = (sv == VAL_ZERO) ? sv : sv - VAL_ONE;
				armed = 1'b1;
				c = pv == VAL_ZERO;
			end else if (!c && ctrCoil && !prev) begin
				pv = pv - VAL_ONE;
				c = pv == VAL_ZERO;
			end
			prev = ctrCoil;
			#1;
			chk(32'(ctrPresentValue), 32'(pv));
			chk(32'(ctrContact), 32'(c));
		end
	endtask

	// Steady coil, ignored coil while latched, clear and level reload
	task automatic counter_cycle();
		run_ctr(16'h0003, 32'h002b_0d5c, 32'h0000_4001);
		run_ctr(16'h0000, 32'h0000_000c, 32'h0000_0001);
	endtask

	task automatic run_seq(input pdtc_step_t last, input logic [31:0] advPat,
		input logic [31:0] clrPat);
		pdtc_step_t step;
		logic prev;
		step = STEP_RESET;
		prev = 1'b0;
		for (int i = 0; i < 32; i++) begin
			@(negedge clk);
			seqLastStep = last;
			seqAdvance = advPat[i];
			seqClear = clrPat[i];
			@(posedge clk);
			if (seqClear)
				step = STEP_RESET;
			else if (seqAdvance && !prev)
				step = (step >= last) ? STEP_RESET : step + STEP_ONE;
			prev = seqAdvance;
			#1;
			chk(32'(seqStep), 32'(step));
			chk(seqStepActive, 32'h0000_0001 << step);
		end
	endtask

	// Held advance, a wrap, mid-run clear and a single-step loop
	task automatic seq_wrap();
		run_seq(5'h02, 32'h0000_0aac, 32'h0000_0101);
		run_seq(5'h00, 32'h0000_0aac, 32'h0000_0001);
	endtask

	task automatic reset_check();
		chk(32'(timerContact), 32'h0);
		chk(32'(timerPresentValue), 32'h0);
		chk(32'(ctrContact), 32'h0);
		chk(32'(ctrPresentValue), 32'h0);
		chk(32'(seqStep), 32'(STEP_RESET));
		chk(seqStepActive, STEP_ACTIVE_RESET);
	endtask

	// Frozen block ignores every input; reset still acts while frozen
	task automatic freeze_reset();
		@(negedge clk);
		clkEn = 1'b0;
		{timerCoil, ctrCoil, counterClearFunction, seqAdvance} = 4'hf;
		seqLastStep = 5'h03;
		repeat (4) begin
			@(posedge clk);
			#1;
			chk(32'(timerPresentValue), 32'h0000_0005);
			chk(32'(timerContact), 32'h0);
			chk(32'(ctrContact), 32'h1);
			chk(32'(ctrPresentValue), 32'h0);
			chk(32'(seqStep), 32'(STEP_RESET));
		end
		@(negedge clk);
		{timerCoil, ctrCoil, counterClearFunction, seqAdvance} = 4'h0;
		reset = 1'b1;
		repeat (2) @(negedge clk);
		reset_check();
		reset = 1'b0;
		clkEn = 1'b1;
		// Level load straight after reset, no clear pulse needed
		run_ctr(16'h0002, 32'h0000_0016, 32'h0000_0000);
	endtask

	initial begin
		reset = 1'b1;
		clkEn = 1'b1;
		{timerCoil, ctrCoil, counterClearFunction, seqAdvance, seqClear} = 5'h00;
		timerSetValue = VAL_ZERO;
		ctrSetValue = VAL_ZERO;
		seqLastStep = STEP_RESET;
		repeat (5) @(negedge clk);
		reset_check();
		reset = 1'b0;
		timer_delay();
		timer_abort();
		counter_cycle();
		seq_wrap();
		freeze_reset();
		final_report();
	end
endmodule
`default_nettype wire
